// ==== ccc_pkg.sv ====
package ccc_pkg;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_CJ_A_DIR = 8'hb5;
    localparam logic [7:0] OP_CJ_A_IMM = 8'hb4;
    localparam logic [4:0] OP_CJ_RN_HI = 5'h17;
    localparam logic [6:0] OP_CJ_RI_HI = 7'h5b;
    localparam logic [7:0] OP_ZERO_ACC = 8'he4;
    localparam logic [7:0] OP_ZERO_CY = 8'hc3;
    localparam logic [7:0] OP_ZERO_BIT = 8'hc2;
    localparam logic [7:0] OP_INV_ACC = 8'hf4;
    localparam logic [7:0] OP_INV_CY = 8'hb3;
    localparam logic [7:0] OP_INV_BIT = 8'hb2;

    // ------------------------------------------------------------
    // Lengths and cycle counts
    // ------------------------------------------------------------
    localparam logic [1:0] CJ_BYTES = 2'h3;
    localparam logic [1:0] BIT_BYTES = 2'h2;
    localparam logic [1:0] ONE_BYTE = 2'h1;
    localparam logic [1:0] CJ_CYCLES = 2'h2;
    localparam logic [1:0] ONE_CYCLE = 2'h1;

    // ------------------------------------------------------------
    // Reset values and port one bit address
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] PORT_RST = 8'hff;
    localparam logic [7:0] PORT_ONE_ADDR = 8'h90;

    // Instruction bytes presented to the core
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] b1;
        logic [7:0] b2;
    } ccc_instr_s;

    // Result of one executed instruction
    typedef struct packed {
        logic hit;
        logic [1:0] len;
        logic [1:0] cycles;
    } ccc_info_s;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } ccc_state_e;

endpackage

// ==== ccc_cmp.sv ====
`timescale 1ns/1ps
module ccc_cmp
    import ccc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] dst_i,
    input wire logic [WIDTH-1:0] src_i,
    output logic ne_o,
    output logic lt_o
);
    initial begin
        if (WIDTH < 1) begin
            $error("ccc_cmp width must be positive");
        end
    end
    assign ne_o = (dst_i != src_i);
    assign lt_o = (dst_i < src_i);
endmodule

// ==== ccc_exec.sv ====
// Contract
// - Compare-jump branches only when operands differ, else falls through.
// - PC advances three bytes; target adds signed last-byte displacement.
// - Carry set when destination unsigned less than source, else cleared.
// - Compare-jump never alters either compared operand.
// - Only A/direct, A/immediate, Rn/immediate, @Ri/immediate compare pairs.
// - Opcode b5 is A versus direct byte, three bytes long.
// - Opcode e4 zeroes accumulator, one byte, one cycle, flags kept.
// - Bit zeroing targets carry or direct bit; c3 zeroes carry.
// - Bit zeroing drives only addressed bit low, other flags kept.
// - Opcode c2 plus bit address zeroes a bit, two bytes, one cycle.
// - Accumulator inversion flips all eight bits, one byte, flags kept.
// - Bit inversion flips carry or direct bit, no other flag.
// - Port bit inversion reads the output latch, never the pin.
`timescale 1ns/1ps
module ccc_exec
    import ccc_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int PC_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire ccc_instr_s instr_i,
    input wire logic [DATA_W-1:0] dir_byte_i,
    input wire logic [DATA_W-1:0] reg_byte_i,
    input wire logic [DATA_W-1:0] ind_byte_i,
    input wire logic bit_val_i,
    input wire logic [DATA_W-1:0] port_pin_i,
    output logic busy_o,
    output logic done_o,
    output logic illegal_o,
    output logic [PC_W-1:0] pc_o,
    output logic [DATA_W-1:0] acc_o,
    output logic carry_o,
    output logic bit_we_o,
    output logic [7:0] bit_addr_o,
    output logic bit_wdata_o,
    output logic [DATA_W-1:0] port_one_latch_o
);
    initial begin
        if (DATA_W != 8) begin
            $error("ccc_exec supports only 8-bit data");
        end
        if (PC_W < 8) begin
            $error("ccc_exec pc too narrow");
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic is_cj_dir;
    logic is_cj_aimm;
    logic is_cj_rn;
    logic is_cj_ri;
    logic is_cj;
    logic is_zacc;
    logic is_zcy;
    logic is_zbit;
    logic is_iacc;
    logic is_icy;
    logic is_ibit;
    logic known;
    logic port_bit;
    logic cur_bit;
    logic [DATA_W-1:0] cj_dst;
    logic [DATA_W-1:0] cj_src;
    logic cj_ne;
    logic cj_lt;
    ccc_info_s info;

    assign is_cj_dir = (instr_i.op == OP_CJ_A_DIR);
    assign is_cj_aimm = (instr_i.op == OP_CJ_A_IMM);
    assign is_cj_rn = (instr_i.op[7:3] == OP_CJ_RN_HI);
    assign is_cj_ri = (instr_i.op[7:1] == OP_CJ_RI_HI);
    assign is_cj = is_cj_dir | is_cj_aimm | is_cj_rn | is_cj_ri;
    assign is_zacc = (instr_i.op == OP_ZERO_ACC);
    assign is_zcy = (instr_i.op == OP_ZERO_CY);
    assign is_zbit = (instr_i.op == OP_ZERO_BIT);
    assign is_iacc = (instr_i.op == OP_INV_ACC);
    assign is_icy = (instr_i.op == OP_INV_CY);
    assign is_ibit = (instr_i.op == OP_INV_BIT);
    assign known = is_cj | is_zacc | is_zcy | is_zbit | is_iacc | is_icy | is_ibit;

    // Port one bits sit at 90..97 in bit space
    assign port_bit = (instr_i.b1[7:3] == PORT_ONE_ADDR[7:3]);
    // Latch, not pin, so an output driven low by a load stays consistent
    assign cur_bit = port_bit ? port_one_latch_o[instr_i.b1[2:0]] : bit_val_i;

    // Pin input unused: read-modify-write ignores pin level by design
    always_comb begin
        cj_dst = acc_o;
        cj_src = instr_i.b1;
        if (is_cj_dir) begin
            cj_src = dir_byte_i;
        end
        if (is_cj_rn) begin
            cj_dst = reg_byte_i;
        end
        if (is_cj_ri) begin
            cj_dst = ind_byte_i;
        end
    end

    ccc_cmp #(
        .WIDTH(DATA_W)
    ) u_cmp (
        .dst_i(cj_dst),
        .src_i(cj_src),
        .ne_o(cj_ne),
        .lt_o(cj_lt)
    );

    always_comb begin
        info.hit = known;
        info.len = ONE_BYTE;
        info.cycles = ONE_CYCLE;
        if (is_cj) begin
            info.len = CJ_BYTES;
            info.cycles = CJ_CYCLES;
        end else if (is_zbit | is_ibit) begin
            info.len = BIT_BYTES;
        end
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    ccc_state_e state_reg;
    logic [PC_W-1:0] pc_next;
    logic [PC_W-1:0] pc_seq;
    logic take;

    assign take = start_i & (state_reg == ST_IDLE);
    assign busy_o = (state_reg == ST_WAIT);
    assign pc_seq = pc_o + PC_W'(info.len);

    always_comb begin
        pc_next = pc_seq;
        if (is_cj && cj_ne) begin
            pc_next = pc_seq + {{(PC_W-8){instr_i.b2[7]}}, instr_i.b2};
        end
    end

    // Compare forms hold the second machine cycle in ST_WAIT
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (take && known && info.cycles == CJ_CYCLES) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
            illegal_o <= 1'b0;
        end else begin
            done_o <= (take && known && info.cycles == ONE_CYCLE) || busy_o;
            illegal_o <= take && !known;
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_o <= PC_RST;
        end else if (take && known) begin
            pc_o <= pc_next;
        end
    end

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            acc_o <= ACC_RST;
        end else if (take && is_zacc) begin
            acc_o <= '0;
        end else if (take && is_iacc) begin
            acc_o <= ~acc_o;
        end
    end

    // ------------------------------------------------------------
    // Carry
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            carry_o <= 1'b0;
        end else if (take && is_cj) begin
            carry_o <= cj_lt;
        end else if (take && is_zcy) begin
            carry_o <= 1'b0;
        end else if (take && is_icy) begin
            carry_o <= ~carry_o;
        end
    end

    // ------------------------------------------------------------
    // Bit write port and port one latch
    // ------------------------------------------------------------
    // Compare forms never raise the write strobe, so operands stay intact
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bit_we_o <= 1'b0;
            bit_addr_o <= '0;
            bit_wdata_o <= 1'b0;
        end else begin
            bit_we_o <= take && (is_zbit || is_ibit);
            bit_addr_o <= instr_i.b1;
            bit_wdata_o <= is_ibit ? ~cur_bit : 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            port_one_latch_o <= PORT_RST;
        end else if (take && port_bit && is_zbit) begin
            port_one_latch_o[instr_i.b1[2:0]] <= 1'b0;
        end else if (take && port_bit && is_ibit) begin
            port_one_latch_o[instr_i.b1[2:0]] <= ~cur_bit;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_cj_taken;
        start_i && !busy_o && is_cj;
    endsequence

    // Second machine cycle: busy first, then done with busy dropped
    sequence s_cj_finish;
        busy_o ##1 (done_o && !busy_o);
    endsequence

    a_cj_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_cj_taken and !cj_ne) |=> pc_o == $past(pc_o) + PC_W'(3))
        else $error("compare fall-through pc wrong");
    a_cj_branch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (s_cj_taken and cj_ne) |=> pc_o == $past(pc_o) + PC_W'(3)
        + {{(PC_W-8){$past(instr_i.b2[7])}}, $past(instr_i.b2)})
        else $error("compare branch pc wrong");
    a_cj_carry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_cj_taken |=> carry_o == $past(cj_dst < cj_src))
        else $error("compare carry wrong");
    a_cj_two_cyc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_cj_taken |=> s_cj_finish)
        else $error("compare not two cycles");
    a_cj_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_cj_taken |=> !bit_we_o && $stable(acc_o))
        else $error("compare touched operand");
    a_zacc_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_zacc |=> acc_o == 8'h00 && $stable(carry_o) && done_o)
        else $error("accumulator zero wrong");
    a_iacc_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_iacc |=> acc_o == ~$past(acc_o) && $stable(carry_o))
        else $error("accumulator invert wrong");
    a_icy_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_icy |=> carry_o != $past(carry_o) && !bit_we_o)
        else $error("carry invert wrong");
    a_zbit_pc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_zbit |=> bit_we_o && !bit_wdata_o && pc_o == $past(pc_o) + PC_W'(2))
        else $error("bit zero wrong");
    a_zcy_value: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_zcy |=> !carry_o && $stable(acc_o))
        else $error("carry zero wrong");
    a_port_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_ibit && port_bit |=>
        port_one_latch_o[$past(instr_i.b1[2:0])] !=
        $past(port_one_latch_o[instr_i.b1[2:0]]))
        else $error("port latch invert wrong");
    a_zbit_latch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_zbit && port_bit |=> !port_one_latch_o[$past(instr_i.b1[2:0])])
        else $error("port latch zero wrong");
    a_zbit_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && (is_zbit || is_ibit) |=> $stable(carry_o) && $stable(acc_o))
        else $error("bit op touched flags");
    a_illegal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && !known |=> illegal_o && $stable(pc_o))
        else $error("unknown opcode executed");
    a_dir_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && instr_i.op == 8'hb5 |-> cj_src == dir_byte_i && cj_dst == acc_o
        && info.len == 2'h3 && info.cycles == 2'h2)
        else $error("direct compare decode wrong");
    a_rmw_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        take && is_ibit |=> bit_we_o && done_o && !busy_o)
        else $error("bit invert timing wrong");
endmodule

// ==== compare_clear_complement_exec_tb_top.sv ====
`timescale 1ns/1ps
module compare_clear_complement_exec_tb_top
    import ccc_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i;
    logic rst_n_i;
    logic start_i;
    ccc_instr_s instr_i;
    logic [7:0] dir_byte_i;
    logic [7:0] reg_byte_i;
    logic [7:0] ind_byte_i;
    logic bit_val_i;
    logic [7:0] port_pin_i;
    logic busy_o;
    logic done_o;
    logic illegal_o;
    logic [15:0] pc_o;
    logic [7:0] acc_o;
    logic carry_o;
    logic bit_we_o;
    logic [7:0] bit_addr_o;
    logic bit_wdata_o;
    logic [7:0] port_one_latch_o;
    int err_total;
    int n_checks;
    int cyc;
    logic [15:0] exp_pc;
    logic is_cj;

    typedef struct packed {
        ccc_instr_s ins;
        logic [7:0] dv;
        logic [7:0] rv;
        logic [7:0] iv;
        logic bv;
        logic [7:0] acc;
        logic cy;
        logic [15:0] pcd;
        logic bwe;
        logic bwd;
        logic [7:0] lat;
    } ccc_row_s;
    ccc_row_s rows [21];

    ccc_exec u_ccc_exec (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .start_i(start_i),
        .instr_i(instr_i),
        .dir_byte_i(dir_byte_i),
        .reg_byte_i(reg_byte_i),
        .ind_byte_i(ind_byte_i),
        .bit_val_i(bit_val_i),
        .port_pin_i(port_pin_i),
        .busy_o(busy_o),
        .done_o(done_o),
        .illegal_o(illegal_o),
        .pc_o(pc_o),
        .acc_o(acc_o),
        .carry_o(carry_o),
        .bit_we_o(bit_we_o),
        .bit_addr_o(bit_addr_o),
        .bit_wdata_o(bit_wdata_o),
        .port_one_latch_o(port_one_latch_o)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic ccc_row_s mk(input logic [7:0] op, b1, b2, dv, rv, iv, input logic bv,
        input logic [7:0] acc, input logic cy, input logic [15:0] pcd, input logic bwe, bwd,
        input logic [7:0] lat);
        mk = {op, b1, b2, dv, rv, iv, bv, acc, cy, pcd, bwe, bwd, lat};
    endfunction

    task automatic chk1(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Request held until the take edge, then dropped there
    task automatic issue(input ccc_instr_s ins, input logic [7:0] dv, rv, iv, input logic bv,
        input logic [7:0] pins);
        @(posedge clk_i);
        start_i <= 1'b1;
        instr_i <= ins;
        dir_byte_i <= dv;
        reg_byte_i <= rv;
        ind_byte_i <= iv;
        bit_val_i <= bv;
        port_pin_i <= pins;
        @(posedge clk_i);
        start_i <= 1'b0;
        #1;
    endtask

    task automatic chk_reset();
        chk16(pc_o, 16'h0000, "pc rst");
        chk8(acc_o, 8'h00, "acc rst");
        chk1(carry_o, 1'b0, "cy rst");
        chk8(port_one_latch_o, 8'hff, "latch rst");
        chk1(busy_o, 1'b0, "busy rst");
        chk1(done_o, 1'b0, "done rst");
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Whole run is about seventy cycles; ceiling leaves wide margin
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            $display("CHECK FAILED t=%0t run timed out", $time);
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0; start_i = 1'b0; instr_i = '0; dir_byte_i = 8'h00; reg_byte_i = 8'h00;
        ind_byte_i = 8'h00; bit_val_i = 1'b0; port_pin_i = 8'hff;
        err_total = 0; n_checks = 0; cyc = 0; exp_pc = 16'h0000;
        rows[0]=mk(8'hf4,8'h00,8'h00,8'h00,8'h00,8'h00,1'b0,8'hff,1'b0,16'h0001,1'b0,1'b0,8'hff);
        rows[1]=mk(8'hb4,8'h12,8'hfe,8'h00,8'h00,8'h00,1'b0,8'hff,1'b0,16'h0001,1'b0,1'b0,8'hff);
        rows[2]=mk(8'hb5,8'h40,8'h10,8'hff,8'h00,8'h00,1'b0,8'hff,1'b0,16'h0003,1'b0,1'b0,8'hff);
        rows[3]=mk(8'hb5,8'h33,8'h80,8'h00,8'hff,8'hff,1'b0,8'hff,1'b0,16'hff83,1'b0,1'b0,8'hff);
        rows[4]=mk(8'hb3,8'h00,8'h00,8'h00,8'h00,8'h00,1'b0,8'hff,1'b1,16'h0001,1'b0,1'b0,8'hff);
        rows[5]=mk(8'hbf,8'h60,8'h05,8'h60,8'h56,8'h60,1'b0,8'hff,1'b1,16'h0008,1'b0,1'b0,8'hff);
        rows[6]=mk(8'hb6,8'h7f,8'h80,8'h7f,8'h7f,8'h80,1'b0,8'hff,1'b0,16'hff83,1'b0,1'b0,8'hff);
        rows[7]=mk(8'hb3,8'h00,8'h00,8'h00,8'h00,8'h00,1'b0,8'hff,1'b1,16'h0001,1'b0,1'b0,8'hff);
        rows[8]=mk(8'hb7,8'h10,8'h40,8'h00,8'h00,8'h10,1'b0,8'hff,1'b0,16'h0003,1'b0,1'b0,8'hff);
        rows[9]=mk(8'hbb,8'h01,8'h00,8'h01,8'h00,8'h01,1'b0,8'hff,1'b1,16'h0003,1'b0,1'b0,8'hff);
        rows[10]=mk(8'he4,8'h00,8'h00,8'h00,8'h00,8'h00,1'b0,8'h00,1'b1,16'h0001,1'b0,1'b0,8'hff);
        rows[11]=mk(8'hb4,8'h00,8'h7f,8'h55,8'h55,8'h55,1'b0,8'h00,1'b0,16'h0003,1'b0,1'b0,8'hff);
        rows[12]=mk(8'hb5,8'h30,8'h02,8'h01,8'h00,8'h00,1'b0,8'h00,1'b1,16'h0005,1'b0,1'b0,8'hff);
        rows[13]=mk(8'hc3,8'h00,8'h00,8'h00,8'h00,8'h00,1'b0,8'h00,1'b0,16'h0001,1'b0,1'b0,8'hff);
        rows[14]=mk(8'hb3,8'h00,8'h00,8'h00,8'h00,8'h00,1'b0,8'h00,1'b1,16'h0001,1'b0,1'b0,8'hff);
        rows[15]=mk(8'hc2,8'h20,8'h00,8'h00,8'h00,8'h00,1'b1,8'h00,1'b1,16'h0002,1'b1,1'b0,8'hff);
        rows[16]=mk(8'hb2,8'h2f,8'h00,8'h00,8'h00,8'h00,1'b1,8'h00,1'b1,16'h0002,1'b1,1'b0,8'hff);
        rows[17]=mk(8'hb2,8'h2e,8'h00,8'h00,8'h00,8'h00,1'b0,8'h00,1'b1,16'h0002,1'b1,1'b1,8'hff);
        rows[18]=mk(8'hc2,8'h92,8'h00,8'h00,8'h00,8'h00,1'b1,8'h00,1'b1,16'h0002,1'b1,1'b0,8'hfb);
        rows[19]=mk(8'hb2,8'h92,8'h00,8'h00,8'h00,8'h00,1'b1,8'h00,1'b1,16'h0002,1'b1,1'b1,8'hff);
        rows[20]=mk(8'hb2,8'h90,8'h00,8'h00,8'h00,8'h00,1'b1,8'h00,1'b1,16'h0002,1'b1,1'b0,8'hfe);
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk_reset();
        foreach (rows[i]) begin
            issue(rows[i].ins, rows[i].dv, rows[i].rv, rows[i].iv, rows[i].bv, 8'hff);
            exp_pc = exp_pc + rows[i].pcd;
            is_cj = (rows[i].ins.op[7:4] == 4'hb) && (rows[i].ins.op[3] || rows[i].ins.op[2]);
            chk16(pc_o, exp_pc, "pc");
            chk8(acc_o, rows[i].acc, "acc");
            chk1(carry_o, rows[i].cy, "carry");
            chk8(port_one_latch_o, rows[i].lat, "latch");
            chk1(illegal_o, 1'b0, "illegal");
            chk1(bit_we_o, rows[i].bwe, "bit we");
            if (rows[i].bwe) begin
                chk8(bit_addr_o, rows[i].ins.b1, "bit addr");
                chk1(bit_wdata_o, rows[i].bwd, "bit data");
            end
            if (is_cj) begin
                chk1(busy_o, 1'b1, "busy");
                @(posedge clk_i);
                #1;
                chk1(done_o, 1'b1, "cj done");
                chk1(busy_o, 1'b0, "busy end");
            end else begin
                chk1(done_o, 1'b1, "done");
            end
        end
        // Back to back inversions: second one must see the first result
        @(posedge clk_i);
        start_i <= 1'b1;
        instr_i <= '{OP_INV_ACC, 8'h00, 8'h00};
        @(posedge clk_i);
        #1;
        chk8(acc_o, 8'hff, "b2b first");
        @(posedge clk_i);
        start_i <= 1'b0;
        #1;
        chk8(acc_o, 8'h00, "b2b second");
        chk16(pc_o, exp_pc + 16'h0002, "b2b pc");
        exp_pc = exp_pc + 16'h0002;
        // Request during the busy cycle of a compare is ignored
        @(posedge clk_i);
        start_i <= 1'b1;
        instr_i <= '{OP_CJ_A_IMM, 8'h01, 8'h02};
        @(posedge clk_i);
        instr_i <= '{OP_INV_ACC, 8'h00, 8'h00};
        #1;
        chk1(busy_o, 1'b1, "refuse busy");
        @(posedge clk_i);
        start_i <= 1'b0;
        #1;
        chk1(carry_o, 1'b1, "refuse cy");
        chk16(pc_o, exp_pc + 16'h0005, "refuse pc");
        exp_pc = exp_pc + 16'h0005;
        @(posedge clk_i);
        #1;
        chk8(acc_o, 8'h00, "refuse acc");
        chk16(pc_o, exp_pc, "refuse pc2");
        // Unknown opcode changes nothing
        issue('{8'ha5, 8'h00, 8'h00}, 8'h00, 8'h00, 8'h00, 1'b0, 8'hff);
        chk1(illegal_o, 1'b1, "illegal");
        chk16(pc_o, exp_pc, "illegal pc");
        chk1(carry_o, 1'b1, "illegal cy");
        // Pins low while latch bit high: inversion must follow the latch
        issue('{OP_INV_BIT, 8'h91, 8'h00}, 8'h00, 8'h00, 8'h00, 1'b0, 8'h00);
        chk8(port_one_latch_o, 8'hfc, "latch read");
        // Second reset in mid-run
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        #1;
        chk_reset();
        report_and_stop();
    end
endmodule
